// ===== timer16_cfg.svh
// Offsets, field positions, reset values and fixed counts of the 16-bit timer
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH
// ---------------------------------------------------------------
// I/O locations
// ---------------------------------------------------------------
`define CTRL_A_ADDR      8'h00
`define CTRL_B_ADDR      8'h01
`define CNT_LO_ADDR      8'h04
`define CNT_HI_ADDR      8'h05
`define CAP_LO_ADDR      8'h06
`define CAP_HI_ADDR      8'h07
`define CMPA_LO_ADDR     8'h08
`define CMPA_HI_ADDR     8'h09
`define FLAG_ADDR        8'h0c
`define MASK_ADDR        8'h0d
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRLB_FILT_BIT   7
`define CTRLB_EDGE_BIT   6
`define FLAG_OVF_BIT     0
`define FLAG_CAP_BIT     5
// ---------------------------------------------------------------
// Reset values and fixed counts
// ---------------------------------------------------------------
`define REG8_RST         8'h00
`define CNT_RST          16'h0000
`define CNT_MAX          16'hffff
`define TOP_8BIT         16'h00ff
`define TOP_9BIT         16'h01ff
`define TOP_10BIT        16'h03ff
`define DIV8_MASK        10'h007
`define DIV64_MASK       10'h03f
`define DIV256_MASK      10'h0ff
`define DIV1024_MASK     10'h3ff
`define FILTER_SAMPLES   4
`endif

// ===== timer16_pkg.sv
// Types shared by the 16-bit timer counter and capture unit
package timer16_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } cpu_req_type;
    typedef enum logic {
        DIR_UP,
        DIR_DOWN
    } count_dir_type;
endpackage : timer16_pkg

// ===== timer16_counter_and_capture.sv
// Counter unit and input capture unit of a 16-bit timer
`include "timer16_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module timer16_counter_and_capture #(
    parameter int FILTER_LEN = `FILTER_SAMPLES
) (
    input  wire logic                      CLOCK_IN,
    input  wire logic                      NRST_IN,
    input  wire timer16_pkg::cpu_req_type  CPU_REQ_IN,
    input  wire logic                      CAPT_PIN_IN,
    input  wire logic                      COMP_OUT_IN,
    input  wire logic                      COMP_SEL_IN,
    input  wire logic                      EXT_CLK_IN,
    input  wire logic                      CAPT_ACK_IN,
    input  wire logic                      OVF_ACK_IN,
    output logic [7:0]                     RDATA_OUT,
    output logic                           CAPT_IRQ_OUT,
    output logic                           OVF_IRQ_OUT,
    output logic                           AT_TOP_OUT,
    output logic                           AT_BOTTOM_OUT
);
    import timer16_pkg::*;
    // ---------------------------------------------------------------
    // Mode decoding
    // ---------------------------------------------------------------
    function automatic logic [15:0] top_value(input logic [3:0] m,
                                              input logic [15:0] cmpa,
                                              input logic [15:0] cap);
        unique case (m)
            4'd1, 4'd5:                     top_value = `TOP_8BIT;
            4'd2, 4'd6:                     top_value = `TOP_9BIT;
            4'd3, 4'd7:                     top_value = `TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15:       top_value = cmpa;
            4'd8, 4'd10, 4'd12, 4'd14:      top_value = cap;
            default:                        top_value = `CNT_MAX;
        endcase
    endfunction : top_value
    function automatic logic dual_slope(input logic [3:0] m);
        dual_slope = (m inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
    endfunction : dual_slope
    function automatic logic fast_pwm(input logic [3:0] m);
        fast_pwm = (m inside {4'd5, 4'd6, 4'd7, 4'd14, 4'd15});
    endfunction : fast_pwm
    function automatic logic cap_is_top(input logic [3:0] m);
        cap_is_top = (m inside {4'd8, 4'd10, 4'd12, 4'd14});
    endfunction : cap_is_top

    // ---------------------------------------------------------------
    // Registers and decode
    // ---------------------------------------------------------------
    logic [7:0]     ctrl_a_q;
    logic [7:0]     ctrl_b_q;
    logic [7:0]     mask_q;
    logic [7:0]     temp_q;
    logic [15:0]    cnt_q;
    logic [15:0]    cnt_d;
    logic [15:0]    cap_q;
    logic [15:0]    cmpa_q;
    logic           ovf_flag_q;
    logic           cap_flag_q;
    count_dir_type  dir_q;
    count_dir_type  dir_d;
    logic [3:0]     mode;
    logic [2:0]     clk_sel;
    logic [15:0]    top;
    logic           wr_cnt_lo;
    logic           wr_cap_lo;
    logic           wr_flag;
    assign mode      = {ctrl_b_q[4:3], ctrl_a_q[1:0]};
    assign clk_sel   = ctrl_b_q[2:0];
    assign top       = top_value(mode, cmpa_q, cap_q);
    assign wr_cnt_lo = CPU_REQ_IN.wr && CPU_REQ_IN.addr == `CNT_LO_ADDR;
    assign wr_cap_lo = CPU_REQ_IN.wr && CPU_REQ_IN.addr == `CAP_LO_ADDR
                       && cap_is_top(mode);
    assign wr_flag   = CPU_REQ_IN.wr && CPU_REQ_IN.addr == `FLAG_ADDR;

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl_a_q <= `REG8_RST;
            ctrl_b_q <= `REG8_RST;
            mask_q   <= `REG8_RST;
        end else if (CPU_REQ_IN.wr) begin
            if (CPU_REQ_IN.addr == `CTRL_A_ADDR) ctrl_a_q <= CPU_REQ_IN.wdata;
            if (CPU_REQ_IN.addr == `CTRL_B_ADDR) ctrl_b_q <= CPU_REQ_IN.wdata;
            if (CPU_REQ_IN.addr == `MASK_ADDR)   mask_q   <= CPU_REQ_IN.wdata;
        end
    end

    // ---------------------------------------------------------------
    // Shared high-byte latch
    // ---------------------------------------------------------------
    // One latch serves every 16-bit register, so an interrupted pair corrupts
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            temp_q <= `REG8_RST;
        end else if (CPU_REQ_IN.wr && CPU_REQ_IN.addr inside
                     {`CNT_HI_ADDR, `CAP_HI_ADDR, `CMPA_HI_ADDR}) begin
            temp_q <= CPU_REQ_IN.wdata;
        end else if (CPU_REQ_IN.rd && CPU_REQ_IN.addr == `CNT_LO_ADDR) begin
            temp_q <= cnt_q[15:8];
        end else if (CPU_REQ_IN.rd && CPU_REQ_IN.addr == `CAP_LO_ADDR) begin
            temp_q <= cap_q[15:8];
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cmpa_q <= `CNT_RST;
        end else if (CPU_REQ_IN.wr && CPU_REQ_IN.addr == `CMPA_LO_ADDR) begin
            cmpa_q <= {temp_q, CPU_REQ_IN.wdata};
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            RDATA_OUT <= `REG8_RST;
        end else if (CPU_REQ_IN.rd) begin
            unique case (CPU_REQ_IN.addr)
                `CTRL_A_ADDR:  RDATA_OUT <= ctrl_a_q;
                `CTRL_B_ADDR:  RDATA_OUT <= ctrl_b_q;
                `CNT_LO_ADDR:  RDATA_OUT <= cnt_q[7:0];
                `CNT_HI_ADDR:  RDATA_OUT <= temp_q;
                `CAP_LO_ADDR:  RDATA_OUT <= cap_q[7:0];
                `CAP_HI_ADDR:  RDATA_OUT <= temp_q;
                `CMPA_LO_ADDR: RDATA_OUT <= cmpa_q[7:0];
                `CMPA_HI_ADDR: RDATA_OUT <= cmpa_q[15:8];
                `FLAG_ADDR:    RDATA_OUT <= {2'h0, cap_flag_q, 4'h0, ovf_flag_q};
                `MASK_ADDR:    RDATA_OUT <= mask_q;
                default:       RDATA_OUT <= `REG8_RST;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    // Bit 0 capture pin, bit 1 comparator, bit 2 external tick
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] clean_q;
    logic [2:0] agree;
    assign agree = ~(sync2_q ^ sync3_q);
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
            clean_q <= 3'h0;
        end else begin
            sync1_q <= {EXT_CLK_IN, COMP_OUT_IN, CAPT_PIN_IN};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            clean_q <= (sync3_q & agree) | (clean_q & ~agree);
        end
    end

    // ---------------------------------------------------------------
    // Tick selection
    // ---------------------------------------------------------------
    logic [9:0] pre_q;
    logic       ext_prev_q;
    logic       tick;
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pre_q      <= 10'h000;
            ext_prev_q <= 1'b0;
        end else begin
            pre_q      <= pre_q + 10'h001;
            ext_prev_q <= clean_q[2];
        end
    end

    always_comb begin
        unique case (clk_sel)
            3'd0: tick = 1'b0;
            3'd1: tick = 1'b1;
            3'd2: tick = (pre_q & `DIV8_MASK) == `DIV8_MASK;
            3'd3: tick = (pre_q & `DIV64_MASK) == `DIV64_MASK;
            3'd4: tick = (pre_q & `DIV256_MASK) == `DIV256_MASK;
            3'd5: tick = (pre_q & `DIV1024_MASK) == `DIV1024_MASK;
            3'd6: tick = ext_prev_q && !clean_q[2];
            3'd7: tick = !ext_prev_q && clean_q[2];
        endcase
    end

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    logic ovf_evt;
    always_comb begin
        cnt_d   = cnt_q;
        dir_d   = dir_q;
        ovf_evt = 1'b0;
        if (wr_cnt_lo) begin
            cnt_d = {temp_q, CPU_REQ_IN.wdata};
        end else if (tick && dual_slope(mode)) begin
            if (dir_q == DIR_UP && cnt_q >= top) begin
                dir_d = DIR_DOWN;
                cnt_d = cnt_q - 16'h0001;
            end else if (dir_q == DIR_DOWN && cnt_q == `CNT_RST) begin
                dir_d   = DIR_UP;
                cnt_d   = cnt_q + 16'h0001;
                ovf_evt = 1'b1;
            end else if (dir_q == DIR_UP) begin
                cnt_d = cnt_q + 16'h0001;
            end else begin
                cnt_d = cnt_q - 16'h0001;
            end
        end else if (tick) begin
            dir_d   = DIR_UP;
            cnt_d   = (cnt_q == top) ? `CNT_RST : cnt_q + 16'h0001;
            ovf_evt = fast_pwm(mode) ? (cnt_q == top)
                                     : (cnt_q == `CNT_MAX);
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cnt_q         <= `CNT_RST;
            dir_q         <= DIR_UP;
            AT_TOP_OUT    <= 1'b0;
            AT_BOTTOM_OUT <= 1'b0;
        end else begin
            cnt_q         <= cnt_d;
            dir_q         <= dir_d;
            AT_TOP_OUT    <= (cnt_d == top);
            AT_BOTTOM_OUT <= (cnt_d == `CNT_RST);
        end
    end

    // ---------------------------------------------------------------
    // Noise filter and edge detector
    // ---------------------------------------------------------------
    logic [FILTER_LEN-1:0] hist_q;
    logic                  trig;
    logic                  filt_q;
    logic                  filt_prev_q;
    logic                  cap_evt;
    assign trig    = COMP_SEL_IN ? clean_q[1] : clean_q[0];
    assign cap_evt = !cap_is_top(mode) && filt_q != filt_prev_q
                     && filt_q == ctrl_b_q[`CTRLB_EDGE_BIT];
    // Filter is always sampled on the system clock, never on the tick
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            hist_q      <= '0;
            filt_q      <= 1'b0;
            filt_prev_q <= 1'b0;
        end else begin
            hist_q      <= {hist_q[FILTER_LEN-2:0], trig};
            filt_prev_q <= filt_q;
            if (!ctrl_b_q[`CTRLB_FILT_BIT]) begin
                filt_q <= trig;
            end else if (&hist_q) begin
                filt_q <= 1'b1;
            end else if (~|hist_q) begin
                filt_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Capture value and flags
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cap_q <= `CNT_RST;
        end else if (wr_cap_lo) begin
            cap_q <= {temp_q, CPU_REQ_IN.wdata};
        end else if (cap_evt) begin
            cap_q <= cnt_q;
        end
    end

    // Hardware set wins over a clear in the same cycle
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            cap_flag_q <= 1'b0;
        end else if (cap_evt) begin
            cap_flag_q <= 1'b1;
        end else if (CAPT_ACK_IN
                     || (wr_flag && CPU_REQ_IN.wdata[`FLAG_CAP_BIT])) begin
            cap_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ovf_flag_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_flag_q <= 1'b1;
        end else if (OVF_ACK_IN
                     || (wr_flag && CPU_REQ_IN.wdata[`FLAG_OVF_BIT])) begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            CAPT_IRQ_OUT <= 1'b0;
            OVF_IRQ_OUT  <= 1'b0;
        end else begin
            CAPT_IRQ_OUT <= cap_flag_q && mask_q[`FLAG_CAP_BIT];
            OVF_IRQ_OUT  <= ovf_flag_q && mask_q[`FLAG_OVF_BIT];
        end
    end

endmodule : timer16_counter_and_capture

`default_nettype wire

// ===== timer16_monitor.sv
// Port-level checker for the 16-bit timer counter and capture unit
`include "timer16_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module timer16_monitor #(
    parameter int FILTER_LEN = `FILTER_SAMPLES
) (
    input wire logic                     CLOCK_IN,
    input wire logic                     NRST_IN,
    input wire timer16_pkg::cpu_req_type CPU_REQ_IN,
    input wire logic                     CAPT_PIN_IN,
    input wire logic                     COMP_OUT_IN,
    input wire logic                     COMP_SEL_IN,
    input wire logic                     CAPT_ACK_IN,
    input wire logic [7:0]               RDATA_OUT,
    input wire logic                     CAPT_IRQ_OUT,
    input wire logic                     OVF_IRQ_OUT,
    input wire logic                     AT_TOP_OUT,
    input wire logic                     AT_BOTTOM_OUT
);
    import timer16_pkg::*;
    // Sync plus filter plus edge stay well inside this span
    localparam int QUIET = 12 + FILTER_LEN;
    logic [2:0] pins_q;
    logic [4:0] quiet_q;
    logic [7:0] mask_copy_q;
    logic       latch_zero_q;
    wire logic  mask_wr = CPU_REQ_IN.wr && CPU_REQ_IN.addr == `MASK_ADDR;
    wire logic  flag_wr = CPU_REQ_IN.wr && CPU_REQ_IN.addr == `FLAG_ADDR;
    wire logic  hi_wr = CPU_REQ_IN.wr && CPU_REQ_IN.addr inside {`CNT_HI_ADDR, `CAP_HI_ADDR, `CMPA_HI_ADDR};
    wire logic  lo_rd = CPU_REQ_IN.rd && (CPU_REQ_IN.addr == `CNT_LO_ADDR || CPU_REQ_IN.addr == `CAP_LO_ADDR);
    wire logic  ctrl_b_wr = CPU_REQ_IN.wr && CPU_REQ_IN.addr == `CTRL_B_ADDR;
    wire logic  settled = int'(quiet_q) >= QUIET;
    // ---------------------------------------------------------------
    // Helper state
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pins_q <= 3'h0;
            quiet_q <= 5'h00;
        end else begin
            pins_q <= {CAPT_PIN_IN, COMP_OUT_IN, COMP_SEL_IN};
            // Control writes may move the edge detector too
            if ({CAPT_PIN_IN, COMP_OUT_IN, COMP_SEL_IN} != pins_q || ctrl_b_wr)
                quiet_q <= 5'h00;
            else if (quiet_q != 5'h1f)
                quiet_q <= quiet_q + 5'h01;
        end
    end
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            mask_copy_q <= 8'h00;
            latch_zero_q <= 1'b1;
        end else begin
            if (mask_wr)
                mask_copy_q <= CPU_REQ_IN.wdata;
            if (hi_wr)
                latch_zero_q <= (CPU_REQ_IN.wdata == 8'h00);
            else if (lo_rd)
                latch_zero_q <= 1'b0;
        end
    end
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!NRST_IN);
    // ---------------------------------------------------------------
    // Assertions and covers
    // ---------------------------------------------------------------
    rdata_hold_a: assert property (!$past(CPU_REQ_IN.rd) && !$past(CPU_REQ_IN.rd, 2) |-> $stable(RDATA_OUT))
        else $error("read data moved without a read");
    unmapped_rd_a: assert property (CPU_REQ_IN.rd && CPU_REQ_IN.addr == 8'h02 |-> ##[1:2] RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    reset_bottom_a: assert property ($rose(NRST_IN) |-> ##[0:2] AT_BOTTOM_OUT)
        else $error("bottom missing after reset");
    cnt_zero_a: assert property (CPU_REQ_IN.wr && CPU_REQ_IN.addr == `CNT_LO_ADDR && CPU_REQ_IN.wdata == 8'h00
        && latch_zero_q |-> ##[1:2] AT_BOTTOM_OUT)
        else $error("zero count write lost");
    capt_mask_a: assert property (!mask_copy_q[5] && !$past(mask_copy_q[5]) |-> !CAPT_IRQ_OUT)
        else $error("capture irq while masked");
    ovf_mask_a: assert property (!mask_copy_q[0] && !$past(mask_copy_q[0]) |-> !OVF_IRQ_OUT)
        else $error("overflow irq while masked");
    cap_cause_a: assert property ($rose(CAPT_IRQ_OUT) |-> !settled || $past(mask_wr) || $past(mask_wr, 2))
        else $error("capture irq without trigger");
    cap_ack_a: assert property (CAPT_ACK_IN && settled |-> ##[1:2] !CAPT_IRQ_OUT)
        else $error("service did not clear capture flag");
    cap_w1c_a: assert property (flag_wr && CPU_REQ_IN.wdata[5] && settled |-> ##[1:2] !CAPT_IRQ_OUT)
        else $error("write one did not clear capture flag");
    cap_keep_a: assert property (flag_wr && !CPU_REQ_IN.wdata[5] && CAPT_IRQ_OUT && settled
        |-> ##2 (CAPT_IRQ_OUT || $past(CAPT_ACK_IN) || $past(mask_wr)))
        else $error("write zero cleared capture flag");
    cap_seen_c: cover property ($rose(CAPT_IRQ_OUT));
    ovf_seen_c: cover property ($rose(OVF_IRQ_OUT));
    top_seen_c: cover property ($rose(AT_TOP_OUT));
endmodule : timer16_monitor
bind timer16_counter_and_capture timer16_monitor #(.FILTER_LEN(FILTER_LEN)) timer16_monitor_i (
    .CLOCK_IN(CLOCK_IN), .NRST_IN(NRST_IN), .CPU_REQ_IN(CPU_REQ_IN), .CAPT_PIN_IN(CAPT_PIN_IN),
    .COMP_OUT_IN(COMP_OUT_IN), .COMP_SEL_IN(COMP_SEL_IN), .CAPT_ACK_IN(CAPT_ACK_IN), .RDATA_OUT(RDATA_OUT),
    .CAPT_IRQ_OUT(CAPT_IRQ_OUT), .OVF_IRQ_OUT(OVF_IRQ_OUT), .AT_TOP_OUT(AT_TOP_OUT), .AT_BOTTOM_OUT(AT_BOTTOM_OUT)
);
`default_nettype wire

// ===== timer16_cpu_model.sv
// CPU bus master model driving the timer's byte-wide register bus
`timescale 1ns/1ps
`default_nettype none
module timer16_cpu_model (
    input  wire logic                     CLOCK_IN,
    input  wire logic [7:0]               RDATA_IN,
    output var  timer16_pkg::cpu_req_type REQ_OUT,
    output var  logic                     CAPT_ACK_OUT,
    output var  logic                     OVF_ACK_OUT
);
    import timer16_pkg::*;
    initial begin
        REQ_OUT = '0;
        CAPT_ACK_OUT = 1'b0;
        OVF_ACK_OUT = 1'b0;
    end
    // Idle bus shows inverted values, never the last ones
    task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge CLOCK_IN);
        #1;
        REQ_OUT = '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge CLOCK_IN);
        #1;
        REQ_OUT = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask : access
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        access(a, 1'b1, d);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        access(a, 1'b0, 8'h00);
        @(posedge CLOCK_IN);
        #1;
        d = RDATA_IN;
    endtask : rd_reg
    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        wr_reg(lo + 8'h01, v[15:8]);
        wr_reg(lo, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        rd_reg(lo, v[7:0]);
        rd_reg(lo + 8'h01, v[15:8]);
    endtask : rd16
    task automatic ack(input logic cap);
        @(posedge CLOCK_IN);
        #1;
        if (cap) CAPT_ACK_OUT = 1'b1; else OVF_ACK_OUT = 1'b1;
        @(posedge CLOCK_IN);
        #1;
        CAPT_ACK_OUT = 1'b0;
        OVF_ACK_OUT = 1'b0;
    endtask : ack
endmodule : timer16_cpu_model
`default_nettype wire

// ===== test_timer16_counter_and_capture.sv
// Testbench for the 16-bit timer counter and capture unit
`include "timer16_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_timer16_counter_and_capture;
    import timer16_pkg::*;
    logic        clock_in, nrst_in, capt_pin, comp_out, comp_sel, ext_clk, capt_ack, ovf_ack;
    logic        capt_irq, ovf_irq, at_top, at_bottom;
    logic [7:0]  rdata, b;
    logic [15:0] v;
    cpu_req_type req;
    int          num_checks, n_mismatch;
    logic [31:0] tops [4] = '{32'h01_00_00ff, 32'h02_00_01ff, 32'h03_00_03ff, 32'h00_08_5a02};
    timer16_counter_and_capture #(.FILTER_LEN(4)) timer16_counter_and_capture_i (
        .CLOCK_IN(clock_in), .NRST_IN(nrst_in), .CPU_REQ_IN(req), .CAPT_PIN_IN(capt_pin),
        .COMP_OUT_IN(comp_out), .COMP_SEL_IN(comp_sel), .EXT_CLK_IN(ext_clk), .CAPT_ACK_IN(capt_ack),
        .OVF_ACK_IN(ovf_ack), .RDATA_OUT(rdata), .CAPT_IRQ_OUT(capt_irq), .OVF_IRQ_OUT(ovf_irq),
        .AT_TOP_OUT(at_top), .AT_BOTTOM_OUT(at_bottom));
    timer16_cpu_model timer16_cpu_model_i (.CLOCK_IN(clock_in), .RDATA_IN(rdata), .REQ_OUT(req),
        .CAPT_ACK_OUT(capt_ack), .OVF_ACK_OUT(ovf_ack));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        timer16_cpu_model_i.wr_reg(a, d);
    endtask : wr
    task automatic chk16(input string nm, input logic [7:0] lo, input logic [15:0] e);
        timer16_cpu_model_i.rd16(lo, v);
        `CHK(nm, e, v)
    endtask : chk16
    task automatic chk_cap(input logic e);
        timer16_cpu_model_i.rd_reg(`FLAG_ADDR, b);
        `CHK("capture_flag", e, b[`FLAG_CAP_BIT])
    endtask : chk_cap
    task automatic pin(input logic l);
        capt_pin = l;
        cyc(20);
    endtask : pin
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    // Whole run needs under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
    initial begin
        {nrst_in, capt_pin, comp_out, comp_sel, ext_clk} = 5'h00;
        cyc(4);
        nrst_in = 1'b1;
        chk16("count_reset", `CNT_LO_ADDR, 16'h0000);
        `CHK("bottom", 1'b1, at_bottom)
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h1234);
        cyc(10);
        chk16("count_stopped", `CNT_LO_ADDR, 16'h1234);
        wr(`CNT_HI_ADDR, 8'h5a);
        wr(`CNT_LO_ADDR, 8'h01);
        wr(`CMPA_LO_ADDR, 8'h02);
        timer16_cpu_model_i.rd_reg(`CMPA_HI_ADDR, b);
        `CHK("cmpa_high", 8'h5a, b)
        chk16("count_shared", `CNT_LO_ADDR, 16'h5a01);
        wr(`CTRL_B_ADDR, 8'h07);
        repeat (5) begin
            ext_clk = 1'b1;
            cyc(4);
            ext_clk = 1'b0;
            cyc(4);
        end
        cyc(8);
        wr(`CTRL_B_ADDR, 8'h00);
        chk16("ext_ticks", `CNT_LO_ADDR, 16'h5a06);
        wr(`CTRL_B_ADDR, 8'h01);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h0000);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'hfff8);
        cyc(20);
        wr(`CTRL_B_ADDR, 8'h00);
        timer16_cpu_model_i.rd_reg(`FLAG_ADDR, b);
        `CHK("ovf_flag", 1'b1, b[`FLAG_OVF_BIT])
        wr(`MASK_ADDR, 8'h01);
        cyc(2);
        `CHK("ovf_irq", 1'b1, ovf_irq)
        timer16_cpu_model_i.ack(1'b0);
        cyc(2);
        `CHK("ovf_irq_ack", 1'b0, ovf_irq)
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h0000);
        wr(`CTRL_B_ADDR, 8'h02);
        cyc(78);
        wr(`CTRL_B_ADDR, 8'h00);
        chk16("div8_ticks", `CNT_LO_ADDR, 16'h000a);
        foreach (tops[i]) begin
            wr(`CTRL_A_ADDR, tops[i][31:24]);
            wr(`CTRL_B_ADDR, tops[i][23:16]);
            timer16_cpu_model_i.wr16(`CNT_LO_ADDR, tops[i][15:0]);
            cyc(3);
            `CHK("at_top", 1'b1, at_top)
            timer16_cpu_model_i.wr16(`CNT_LO_ADDR, tops[i][15:0] - 16'h0001);
            cyc(3);
            `CHK("below_top", 1'b0, at_top)
        end
        wr(`CTRL_A_ADDR, 8'h00);
        wr(`CTRL_B_ADDR, 8'h40);
        wr(`FLAG_ADDR, 8'h20);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'habcd);
        pin(1'b1);
        chk_cap(1'b1);
        chk16("capture", `CAP_LO_ADDR, 16'habcd);
        wr(`FLAG_ADDR, 8'h20);
        pin(1'b0);
        chk_cap(1'b0);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h1111);
        pin(1'b1);
        chk16("capture_rise", `CAP_LO_ADDR, 16'h1111);
        wr(`CTRL_B_ADDR, 8'h00);
        wr(`FLAG_ADDR, 8'h20);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h2222);
        pin(1'b0);
        chk16("overwrite", `CAP_LO_ADDR, 16'h2222);
        wr(`MASK_ADDR, 8'h20);
        wr(`FLAG_ADDR, 8'h00);
        chk_cap(1'b1);
        `CHK("capt_irq", 1'b1, capt_irq)
        timer16_cpu_model_i.ack(1'b1);
        cyc(2);
        `CHK("capt_irq_ack", 1'b0, capt_irq)
        comp_sel = 1'b1;
        cyc(20);
        wr(`CTRL_B_ADDR, 8'h40);
        wr(`FLAG_ADDR, 8'h20);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h3333);
        pin(1'b1);
        chk_cap(1'b0);
        comp_out = 1'b1;
        cyc(20);
        chk_cap(1'b1);
        chk16("comp_capture", `CAP_LO_ADDR, 16'h3333);
        comp_sel = 1'b0;
        cyc(20);
        wr(`CTRL_B_ADDR, 8'hc0);
        timer16_cpu_model_i.wr16(`CNT_LO_ADDR, 16'h4444);
        pin(1'b0);
        wr(`FLAG_ADDR, 8'h20);
        capt_pin = 1'b1;
        cyc(2);
        pin(1'b0);
        chk_cap(1'b0);
        pin(1'b1);
        chk_cap(1'b1);
        chk16("filt_capture", `CAP_LO_ADDR, 16'h4444);
        timer16_cpu_model_i.wr16(`CAP_LO_ADDR, 16'h7777);
        chk16("cap_wr_refused", `CAP_LO_ADDR, 16'h4444);
        wr(`CTRL_B_ADDR, 8'h18);
        timer16_cpu_model_i.wr16(`CAP_LO_ADDR, 16'h7777);
        chk16("cap_wr_mode12", `CAP_LO_ADDR, 16'h7777);
        wr(`FLAG_ADDR, 8'h20);
        pin(1'b0);
        pin(1'b1);
        chk_cap(1'b0);
        timer16_cpu_model_i.rd_reg(8'h02, b);
        `CHK("unmapped", 8'h00, b)
        final_report();
    end
endmodule : test_timer16_counter_and_capture
`default_nettype wire
